// File: src/phy_basic_mgmt_registers.sv
// Purpose: basic control, basic status and identifier registers of a 10/100 transceiver
// Assumes: all inputs synchronous to clk; mode straps stable around reset release
// Notes: registers are reached only through the serial management pins
//   identifier registers are writable and keep their value over soft reset
//   soft reset keeps speed, duplex and negotiation enable, clears the rest
//   status latches are released by a status read only
//
// What this block and the managing station do
// RQ1 - control bit 15 soft reset, self clearing
// RQ2 - soft reset keeps register config, no strap resample
// RQ3 - station writes other control bits zero with reset
// RQ4 - bit 14 selects loopback
// RQ5 - bit 13 forces speed unless negotiating
// RQ6 - bit 12 enables negotiation, overrides forced bits
// RQ7 - station clears negotiation before power down
// RQ8 - bit 11 selects general power down
// RQ9 - bit 10 isolates the data interface
// RQ10 - bit 9 restarts negotiation, self clearing
// RQ11 - bit 8 forces duplex unless negotiating
// RQ12 - bit 7 enables collision test
// RQ13 - speed, negotiation, duplex defaults from straps
// RQ14 - fixed ability bits in status register
// RQ15 - status bit 5 shows negotiation done
// RQ16 - status bit 4 remote fault latched high
// RQ17 - status bit 2 link latched low
// RQ18 - status bit 1 jabber latched high
// RQ19 - status bit 0 reads one
// RQ20 - index 2 holds identifier bits 3-18
// RQ21 - index 3 holds identifier, model, revision
// RQ22 - latched high holds until read, then follows
// RQ23 - latched low holds until read
// RQ24 - reserved bits read zero, ignore writes
module phy_basic_mgmt_registers #(
	parameter logic [15:0] OUI_HIGH = 16'h5A5A, // arbitrary value
	parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
	parameter logic [5:0] MODEL = 6'h2A, // arbitrary value
	parameter logic [3:0] REVISION = 4'h3, // arbitrary value
	parameter int SOFT_RESET_LEN = phy_mgmt_pkg::SOFT_RESET_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] phy_addr,
	// configuration straps
	input wire logic [2:0] mode_strap,
	// line conditions
	input wire logic link_up,
	input wire logic remote_fault,
	input wire logic jabber,
	input wire logic an_done,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	// operating configuration
	output logic soft_reset_busy,
	output logic loopback,
	output logic speed_100,
	output logic full_duplex,
	output logic an_enable,
	output logic an_restart,
	output logic power_down,
	output logic isolate,
	output logic col_test
);
	reg_port_if port ();

	// control register fields
	logic ctl_speed;
	logic ctl_duplex;
	logic ctl_restart;
	logic strap_taken;
	logic [4:0] reset_cnt;

	// identifier registers
	logic [15:0] id_high;
	logic [15:0] id_low;

	// status latches
	logic fault_latch;
	logic link_latch;
	logic jabber_latch;

	// decoded accesses
	logic wr_control;
	logic wr_id_high;
	logic wr_id_low;
	logic rd_status;
	logic ctl_accept;

	logic [15:0] rdata;

	// ============================================================
	// helpers
	function automatic logic hits(input logic [4:0] addr, input logic [4:0] idx, input logic strobe);
		hits = strobe && addr == idx;
	endfunction

	function automatic logic [2:0] strap_config(input logic [2:0] mode);
		// {negotiation enable, speed 100, full duplex}
		case (mode)
			3'h0: strap_config = 3'h0;
			3'h1: strap_config = 3'h1;
			3'h2: strap_config = 3'h2;
			3'h3: strap_config = 3'h3;
			default: strap_config = 3'h7;
		endcase
	endfunction

	function automatic logic [15:0] control_word(
		input logic busy,
		input logic lb,
		input logic spd,
		input logic an,
		input logic pd,
		input logic iso,
		input logic rs,
		input logic dup,
		input logic col
	);
		control_word = 16'h0000;
		control_word[phy_mgmt_pkg::CTL_SOFT_RESET] = busy;
		control_word[phy_mgmt_pkg::CTL_LOOPBACK] = lb;
		control_word[phy_mgmt_pkg::CTL_SPEED] = spd;
		control_word[phy_mgmt_pkg::CTL_AN_ENABLE] = an;
		control_word[phy_mgmt_pkg::CTL_POWER_DOWN] = pd;
		control_word[phy_mgmt_pkg::CTL_ISOLATE] = iso;
		control_word[phy_mgmt_pkg::CTL_AN_RESTART] = rs;
		control_word[phy_mgmt_pkg::CTL_DUPLEX] = dup;
		control_word[phy_mgmt_pkg::CTL_COL_TEST] = col;
	endfunction

	// fixed ability bits merged with live and latched condition bits
	function automatic logic [15:0] status_word(
		input logic done,
		input logic fault,
		input logic link,
		input logic jab
	);
		status_word = phy_mgmt_pkg::STS_ABILITY; // RQ14 RQ19 RQ24
		status_word[phy_mgmt_pkg::STS_AN_DONE] = done; // RQ15
		status_word[phy_mgmt_pkg::STS_REMOTE_FAULT] = fault; // RQ16
		status_word[phy_mgmt_pkg::STS_LINK] = link; // RQ17
		status_word[phy_mgmt_pkg::STS_JABBER] = jab; // RQ18
	endfunction

	// ============================================================
	// frame engine
	smi_frame_engine engine (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.phy_addr(phy_addr),
		.port(port.engine)
	);

	assign wr_control = hits(port.addr, phy_mgmt_pkg::REG_CONTROL, port.wr);
	assign wr_id_high = hits(port.addr, phy_mgmt_pkg::REG_ID_HIGH, port.wr);
	assign wr_id_low = hits(port.addr, phy_mgmt_pkg::REG_ID_LOW, port.wr);
	assign rd_status = hits(port.addr, phy_mgmt_pkg::REG_STATUS, port.rd);
	assign ctl_accept = wr_control && !soft_reset_busy;
	assign port.rdata = rdata;

	// ============================================================
	// soft reset sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reset_cnt <= 5'h00;
			soft_reset_busy <= 1'b0;
		end else if (ce) begin
			if (ctl_accept && port.wdata[phy_mgmt_pkg::CTL_SOFT_RESET]) begin
				reset_cnt <= 5'(SOFT_RESET_LEN - 1); // RQ1
				soft_reset_busy <= 1'b1; // RQ1
			end else if (reset_cnt != 5'h00) begin
				reset_cnt <= reset_cnt - 5'h01;
			end else begin
				soft_reset_busy <= 1'b0; // RQ1
			end
		end
	end

	// ============================================================
	// strap capture and strap-defaulted fields
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_taken <= 1'b0;
			an_enable <= 1'b0;
			ctl_speed <= 1'b0;
			ctl_duplex <= 1'b0;
		end else if (ce) begin
			if (!strap_taken) begin
				strap_taken <= 1'b1;
				{an_enable, ctl_speed, ctl_duplex} <= strap_config(mode_strap); // RQ13
			end else if (ctl_accept && !port.wdata[phy_mgmt_pkg::CTL_SOFT_RESET]) begin // RQ2
				an_enable <= port.wdata[phy_mgmt_pkg::CTL_AN_ENABLE]; // RQ6
				ctl_speed <= port.wdata[phy_mgmt_pkg::CTL_SPEED]; // RQ5
				ctl_duplex <= port.wdata[phy_mgmt_pkg::CTL_DUPLEX]; // RQ11
			end
			// soft reset write leaves these three untouched
		end
	end

	// ============================================================
	// plain control fields, cleared by soft reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loopback <= 1'b0;
			power_down <= 1'b0;
			isolate <= 1'b0;
			col_test <= 1'b0;
		end else if (ce) begin
			if (ctl_accept) begin
				if (port.wdata[phy_mgmt_pkg::CTL_SOFT_RESET]) begin
					loopback <= 1'b0; // RQ1
					power_down <= 1'b0;
					isolate <= 1'b0;
					col_test <= 1'b0;
				end else begin
					loopback <= port.wdata[phy_mgmt_pkg::CTL_LOOPBACK]; // RQ4
					power_down <= port.wdata[phy_mgmt_pkg::CTL_POWER_DOWN]; // RQ8
					isolate <= port.wdata[phy_mgmt_pkg::CTL_ISOLATE]; // RQ9
					col_test <= port.wdata[phy_mgmt_pkg::CTL_COL_TEST]; // RQ12
				end
			end
		end
	end

	// ============================================================
	// negotiation restart, self clearing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctl_restart <= 1'b0;
			an_restart <= 1'b0;
		end else if (ce) begin
			an_restart <= ctl_restart; // RQ10
			if (ctl_accept && !port.wdata[phy_mgmt_pkg::CTL_SOFT_RESET]
				&& port.wdata[phy_mgmt_pkg::CTL_AN_RESTART]) begin
				ctl_restart <= 1'b1; // RQ10
			end else begin
				ctl_restart <= 1'b0; // RQ10
			end
		end
	end

	// ============================================================
	// effective speed and duplex
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speed_100 <= 1'b0;
			full_duplex <= 1'b0;
		end else if (ce) begin
			if (an_enable) begin
				speed_100 <= an_speed_100; // RQ6
				full_duplex <= an_full_duplex; // RQ6
			end else begin
				speed_100 <= ctl_speed; // RQ5
				full_duplex <= ctl_duplex; // RQ11
			end
		end
	end

	// ============================================================
	// identifier registers, writable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			id_high <= OUI_HIGH; // RQ20
			id_low <= {OUI_LOW, MODEL, REVISION}; // RQ21
		end else if (ce) begin
			if (wr_id_high) begin
				id_high <= port.wdata;
			end
			if (wr_id_low) begin
				id_low <= port.wdata;
			end
		end
	end

	// ============================================================
	// latched status bits; a new event wins over the read release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_latch <= 1'b0;
			jabber_latch <= 1'b0;
			link_latch <= 1'b0;
		end else if (ce) begin
			if (rd_status) begin
				fault_latch <= remote_fault; // RQ22
				jabber_latch <= jabber; // RQ22
				link_latch <= link_up; // RQ23
			end else begin
				fault_latch <= fault_latch | remote_fault; // RQ16
				jabber_latch <= jabber_latch | jabber; // RQ18
				link_latch <= link_latch & link_up; // RQ17
			end
		end
	end

	// ============================================================
	// read data capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (ce) begin
			if (port.rd) begin
				case (port.addr)
					phy_mgmt_pkg::REG_CONTROL: begin
						rdata <= control_word(
							soft_reset_busy,
							loopback,
							ctl_speed,
							an_enable,
							power_down,
							isolate,
							ctl_restart,
							ctl_duplex,
							col_test
						); // RQ24
					end
					phy_mgmt_pkg::REG_STATUS: begin
						rdata <= status_word(an_done, fault_latch, link_latch, jabber_latch); // RQ15 RQ16 RQ17 RQ18
					end
					phy_mgmt_pkg::REG_ID_HIGH: begin
						rdata <= id_high; // RQ20
					end
					phy_mgmt_pkg::REG_ID_LOW: begin
						rdata <= id_low; // RQ21
					end
					default: begin
						rdata <= 16'h0000;
					end
				endcase
			end
		end
	end
endmodule

// File: src/phy_mgmt_pkg.sv
// Purpose: shared constants and types of the basic management register bank
// Assumes: 20 MHz system clock
// Notes: register indices are management frame register addresses
package phy_mgmt_pkg;
	// ============================================================
	// register indices
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_ID_HIGH = 5'h02;
	localparam logic [4:0] REG_ID_LOW = 5'h03;
	// ============================================================
	// control bit positions
	localparam int CTL_SOFT_RESET = 15;
	localparam int CTL_LOOPBACK = 14;
	localparam int CTL_SPEED = 13;
	localparam int CTL_AN_ENABLE = 12;
	localparam int CTL_POWER_DOWN = 11;
	localparam int CTL_ISOLATE = 10;
	localparam int CTL_AN_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_COL_TEST = 7;
	// ============================================================
	// status bit positions and fixed ability bits
	localparam int STS_AN_DONE = 5;
	localparam int STS_REMOTE_FAULT = 4;
	localparam int STS_LINK = 2;
	localparam int STS_JABBER = 1;
	localparam logic [15:0] STS_ABILITY = 16'h7809;
	// ============================================================
	// identifier field layout
	localparam int ID_OUI_LSB = 10;
	localparam int ID_MODEL_LSB = 4;
	// ============================================================
	// frame format
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HEADER_BITS = 5'h0D;
	localparam logic [4:0] DATA_LAST = 5'h0F;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SOFT_RESET_NS = 1000;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		FR_PREAMBLE = 3'h0,
		FR_HEADER = 3'h1,
		FR_TURN = 3'h3,
		FR_DATA = 3'h2
	} frame_state_t;
endpackage

// File: src/reg_port_if.sv
// Purpose: register access carrier between the frame engine and the register bank
// Assumes: one clock, all strobes are one-cycle pulses
// Notes: rdata is valid from the cycle after a rd pulse onward
interface reg_port_if;
	logic [4:0] addr;
	logic rd;
	logic wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport engine (output addr, output rd, output wr, output wdata, input rdata);
	modport regs (input addr, input rd, input wr, input wdata, output rdata);
endinterface

// File: src/smi_frame_engine.sv
// Purpose: serial management frame decoder driving register reads and writes
// Assumes: mdc is far slower than clk and sampled as a plain synchronous input
// Notes: data is driven right after a rising mdc, sampled by the station on the next rising edge
module smi_frame_engine (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// management pins
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] phy_addr,
	// register side
	reg_port_if.engine port
);
	phy_mgmt_pkg::frame_state_t state;
	logic mdc_q;
	logic rise;
	logic [5:0] ones;
	logic [4:0] cnt;
	logic [15:0] shreg;
	logic is_read;
	logic is_ours;

	assign rise = mdc & ~mdc_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mdc_q <= 1'b0;
		end else if (ce) begin
			mdc_q <= mdc;
		end
	end

	// ============================================================
	// frame sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= phy_mgmt_pkg::FR_PREAMBLE;
			ones <= 6'h00;
			cnt <= 5'h00;
			shreg <= 16'h0000;
			is_read <= 1'b0;
			is_ours <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			port.rd <= 1'b0;
			port.wr <= 1'b0;
			port.addr <= 5'h00;
			port.wdata <= 16'h0000;
		end else if (ce) begin
			port.rd <= 1'b0;
			port.wr <= 1'b0;
			if (rise) begin
				case (state)
					phy_mgmt_pkg::FR_PREAMBLE: begin
						mdio_oe <= 1'b0;
						if (mdio_in) begin
							if (ones != phy_mgmt_pkg::PREAMBLE_LEN) begin
								ones <= ones + 6'h01;
							end
						end else if (ones == phy_mgmt_pkg::PREAMBLE_LEN) begin
							state <= phy_mgmt_pkg::FR_HEADER;
							cnt <= 5'h00;
							ones <= 6'h00;
						end else begin
							ones <= 6'h00;
						end
					end
					phy_mgmt_pkg::FR_HEADER: begin
						shreg <= {shreg[14:0], mdio_in};
						cnt <= cnt + 5'h01;
						if (cnt == phy_mgmt_pkg::HEADER_BITS - 5'h01) begin
							// bits: start(1) op(2) phy(5) reg(5)
							is_ours <= shreg[11] && shreg[8:4] == phy_addr &&
								(shreg[10:9] == phy_mgmt_pkg::OP_READ || shreg[10:9] == phy_mgmt_pkg::OP_WRITE);
							is_read <= shreg[10:9] == phy_mgmt_pkg::OP_READ;
							port.addr <= {shreg[3:0], mdio_in};
							port.rd <= shreg[11] && shreg[8:4] == phy_addr && shreg[10:9] == phy_mgmt_pkg::OP_READ;
							cnt <= 5'h00;
							state <= phy_mgmt_pkg::FR_TURN;
						end
					end
					phy_mgmt_pkg::FR_TURN: begin
						cnt <= cnt + 5'h01;
						if (cnt == 5'h00) begin
							mdio_oe <= is_ours & is_read;
							mdio_out <= 1'b0;
						end else begin
							mdio_out <= port.rdata[15];
							shreg <= {port.rdata[14:0], 1'b0};
							cnt <= 5'h00;
							state <= phy_mgmt_pkg::FR_DATA;
						end
					end
					phy_mgmt_pkg::FR_DATA: begin
						cnt <= cnt + 5'h01;
						if (is_read) begin
							mdio_out <= shreg[15];
							shreg <= {shreg[14:0], 1'b0};
						end else begin
							shreg <= {shreg[14:0], mdio_in};
						end
						if (cnt == phy_mgmt_pkg::DATA_LAST) begin
							mdio_oe <= 1'b0;
							port.wr <= is_ours & ~is_read;
							port.wdata <= {shreg[14:0], mdio_in};
							state <= phy_mgmt_pkg::FR_PREAMBLE;
						end
					end
					default: begin
						state <= phy_mgmt_pkg::FR_PREAMBLE;
					end
				endcase
			end
		end
	end
endmodule

// File: testbench/phy_basic_mgmt_registers_tb.sv
// Purpose: self-checking bench of the basic management register bank
// Assumes: inputs driven on falling clk edges
// Notes: short soft reset length for simulation
module phy_basic_mgmt_registers_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SR_LEN = 3;
	localparam logic [4:0] PA = 5'h05;
	localparam logic [15:0] OUIH = 16'h2C3D; // arbitrary value
	localparam logic [5:0] OUIL = 6'h0B; // arbitrary value
	localparam logic [5:0] MDL = 6'h31; // arbitrary value
	localparam logic [3:0] REV = 4'h6; // arbitrary value
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic mdc, mdio_in, mdio_out, mdio_oe;
	logic [2:0] mode_strap = 3'h0;
	logic link_up = 1'b0, remote_fault = 1'b0, jabber = 1'b0, an_done = 1'b0;
	logic an_speed_100 = 1'b0, an_full_duplex = 1'b0;
	logic soft_reset_busy, loopback, speed_100, full_duplex, an_enable, an_restart, power_down, isolate, col_test;
	int err_total = 0, check_count = 0, busy_seen = 0, restarts = 0;
	logic [15:0] lfsr = 16'h9699, ctl, rd;
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (soft_reset_busy === 1'b1)
			busy_seen++;
		if (an_restart === 1'b1)
			restarts++;
	end
	phy_basic_mgmt_registers #(.OUI_HIGH(OUIH), .OUI_LOW(OUIL), .MODEL(MDL), .REVISION(REV),
		.SOFT_RESET_LEN(SR_LEN)) DUT (.clk(clk), .rst(rst), .ce(ce), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(PA), .mode_strap(mode_strap), .link_up(link_up),
		.remote_fault(remote_fault), .jabber(jabber), .an_done(an_done), .an_speed_100(an_speed_100),
		.an_full_duplex(an_full_duplex), .soft_reset_busy(soft_reset_busy), .loopback(loopback),
		.speed_100(speed_100), .full_duplex(full_duplex), .an_enable(an_enable), .an_restart(an_restart),
		.power_down(power_down), .isolate(isolate), .col_test(col_test));
	smi_station smi (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
	// ============================================================
	// helpers
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic chk_outs();
		logic [7:0] e;
		e = {1'b0, ctl[14], ctl[12] ? an_speed_100 : ctl[13], ctl[12], ctl[11], ctl[10],
			ctl[12] ? an_full_duplex : ctl[8], ctl[7]};
		chk("outputs", {8'h00, e}, {8'h00, soft_reset_busy, loopback, speed_100, an_enable, power_down,
			isolate, full_duplex, col_test});
	endtask
	task automatic rreg(input logic [4:0] ra, output logic [15:0] d);
		smi.xfer(phy_mgmt_pkg::OP_READ, PA, ra, 16'h0000, d);
	endtask
	task automatic wreg(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		smi.xfer(phy_mgmt_pkg::OP_WRITE, PA, ra, d, x);
		repeat (3) @(negedge clk);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		finish_test();
	end
	// ============================================================
	// main sequence
	initial begin
		for (int m = 0; m < 8; m++) begin
			mode_strap = m[2:0];
			rst = 1'b1;
			repeat (20) @(negedge clk);
			rst = 1'b0;
			ctl = {2'b00, mode_strap[2] | mode_strap[1], mode_strap[2], 3'b000, mode_strap[2] | mode_strap[0], 8'h00};
			rreg(phy_mgmt_pkg::REG_CONTROL, rd);
			chk("control", ctl, rd);
			chk_outs();
		end
		link_up = 1'b1;
		an_done = 1'b1;
		rreg(phy_mgmt_pkg::REG_STATUS, rd);
		rreg(phy_mgmt_pkg::REG_STATUS, rd);
		chk("status", 16'h782D, rd);
		remote_fault = 1'b1;
		jabber = 1'b1;
		link_up = 1'b0;
		@(negedge clk);
		remote_fault = 1'b0;
		jabber = 1'b0;
		link_up = 1'b1;
		rreg(phy_mgmt_pkg::REG_STATUS, rd);
		chk("status", 16'h783B, rd);
		rreg(phy_mgmt_pkg::REG_STATUS, rd);
		chk("status", 16'h782D, rd);
		jabber = 1'b1;
		an_done = 1'b0;
		rreg(phy_mgmt_pkg::REG_STATUS, rd);
		rreg(phy_mgmt_pkg::REG_STATUS, rd);
		chk("status", 16'h780F, rd);
		jabber = 1'b0;
		rreg(phy_mgmt_pkg::REG_ID_HIGH, rd);
		chk("id high", OUIH, rd);
		rreg(phy_mgmt_pkg::REG_ID_LOW, rd);
		chk("id low", {OUIL, MDL, REV}, rd);
		lfsr = nxt(lfsr);
		wreg(phy_mgmt_pkg::REG_ID_LOW, lfsr);
		rreg(phy_mgmt_pkg::REG_ID_LOW, rd);
		chk("id low", lfsr, rd);
		rreg(5'h04, rd);
		chk("unmapped", 16'h0000, rd);
		smi.xfer(phy_mgmt_pkg::OP_READ, PA ^ 5'h01, phy_mgmt_pkg::REG_ID_HIGH, 16'h0000, rd);
		chk("foreign read", 16'hFFFF, rd);
		smi.xfer(phy_mgmt_pkg::OP_WRITE, PA ^ 5'h01, phy_mgmt_pkg::REG_CONTROL, 16'h4000, rd);
		smi.xfer(2'b11, PA, phy_mgmt_pkg::REG_CONTROL, 16'h4000, rd);
		rreg(phy_mgmt_pkg::REG_CONTROL, rd);
		chk("control", ctl, rd);
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			smi.half = 4 + 3 * (i % 2);
			an_speed_100 = lfsr[0];
			an_full_duplex = lfsr[1];
			ctl = lfsr & 16'h7D80;
			if (ctl[11]) begin
				ctl[12] = 1'b0;
				wreg(phy_mgmt_pkg::REG_CONTROL, 16'h0000);
			end
			wreg(phy_mgmt_pkg::REG_CONTROL, ctl);
			rreg(phy_mgmt_pkg::REG_CONTROL, rd);
			chk("control", ctl, rd);
			chk_outs();
		end
		ctl[11] = 1'b0;
		wreg(phy_mgmt_pkg::REG_CONTROL, ctl | 16'h0200);
		chk("restarts", 16'h0001, restarts[15:0]);
		rreg(phy_mgmt_pkg::REG_CONTROL, rd);
		chk("control", ctl, rd);
		ctl = (ctl & 16'h3100) | 16'h4480;
		wreg(phy_mgmt_pkg::REG_CONTROL, ctl);
		wreg(phy_mgmt_pkg::REG_CONTROL, 16'h8000);
		for (int k = 0; k < 100 && soft_reset_busy !== 1'b0; k++)
			@(negedge clk);
		chk("busy cycles", 16'(SR_LEN), busy_seen[15:0]);
		ctl = ctl & 16'h3100;
		rreg(phy_mgmt_pkg::REG_CONTROL, rd);
		chk("control", ctl, rd);
		chk_outs();
		finish_test();
	end
endmodule

// File: testbench/phy_mgmt_sva.sv
// Purpose: port level checks of the basic management register bank
// Assumes: one clock domain, rst async active high
// Notes: bound to the register bank top module
module phy_mgmt_sva #(
	parameter int SOFT_RESET_LEN = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// management pins
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	// line conditions
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	// operating configuration
	input wire logic soft_reset_busy,
	input wire logic loopback,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic an_enable,
	input wire logic an_restart,
	input wire logic power_down,
	input wire logic isolate,
	input wire logic col_test
);
	timeunit 1ns;
	timeprecision 1ns;
	int busy_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ============================================================
	// soft reset length counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			busy_cnt <= 0;
		else
			busy_cnt <= soft_reset_busy ? busy_cnt + 1 : 0;
	end
	AST_RESTART_PULSE: assert property (an_restart |=> !an_restart)
		else $error("restart longer than one cycle");
	AST_SPEED_NEG: assert property (an_enable && $past(an_enable) |-> speed_100 == $past(an_speed_100))
		else $error("speed not negotiated value");
	AST_DUPLEX_NEG: assert property (an_enable && $past(an_enable) |-> full_duplex == $past(an_full_duplex))
		else $error("duplex not negotiated value");
	AST_SR_LEN: assert property ($fell(soft_reset_busy) |-> $past(busy_cnt) == SOFT_RESET_LEN - 1)
		else $error("soft reset length wrong");
	AST_SR_BOUND: assert property (soft_reset_busy |-> busy_cnt < SOFT_RESET_LEN)
		else $error("soft reset does not clear");
	AST_SR_CLEARS: assert property ($fell(soft_reset_busy) |-> !loopback && !power_down && !isolate && !col_test)
		else $error("soft reset left control bits set");
	AST_SR_KEEPS: assert property (soft_reset_busy |-> $stable(an_enable))
		else $error("soft reset changed negotiation enable");
	AST_TURN_ZERO: assert property ($rose(mdio_oe) |-> !mdio_out)
		else $error("turnaround not driven low");
	AST_OE_ON_RISE: assert property ($changed(mdio_oe) |-> $past(mdc) && !$past(mdc, 2))
		else $error("data enable moved off a clock rise");
	cover property ($fell(soft_reset_busy));
	cover property (an_restart);
	cover property ($rose(mdio_oe));
endmodule

bind phy_basic_mgmt_registers phy_mgmt_sva #(.SOFT_RESET_LEN(SOFT_RESET_LEN)) sva_chk (.clk(clk), .rst(rst),
	.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .an_speed_100(an_speed_100),
	.an_full_duplex(an_full_duplex), .soft_reset_busy(soft_reset_busy), .loopback(loopback),
	.speed_100(speed_100), .full_duplex(full_duplex), .an_enable(an_enable), .an_restart(an_restart),
	.power_down(power_down), .isolate(isolate), .col_test(col_test));

// File: testbench/smi_station.sv
// Purpose: station management controller model driving frames
// Assumes: driven on falling clk edges, half is the mdc half period in clk cycles
// Notes: mdc stands low between frames, released data line is pulled up
module smi_station (
	// clock
	input wire logic clk,
	// management pins
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic st_out = 1'b1;
	logic st_oe = 1'b0;
	int half = 4;
	initial mdc = 1'b0;
	assign mdio_in = mdio_oe ? mdio_out : (st_oe ? st_out : 1'b1);
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] fr;
		fr = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++) begin
			@(negedge clk);
			mdc = 1'b0;
			st_oe = (op == 2'b01) || (i < 46);
			st_out = fr[63 - i];
			repeat (half) @(negedge clk);
			if (i >= 48)
				rd[63 - i] = mdio_in;
			mdc = 1'b1;
			repeat (half - 1) @(negedge clk);
		end
		@(negedge clk);
		mdc = 1'b0;
		st_oe = 1'b0;
	endtask
endmodule
